// *** slpb_pkg.sv ***
// Purpose: Shared constants and carrier types for the stepper loop parameter bank
// Assumes: 40 MHz clock, 16-bit holding registers addressed by register number
// Notes: Register numbers, reset values and legal ranges live here once
package slpb_pkg;

   localparam int CLK_HZ = 40000000;
   localparam int TICK_US = 50;
   localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;

   // Step test phase lengths
   localparam int STEP_ZERO_US = 1000;
   localparam int STEP_HIGH_US = 10000;
   localparam int STEP_ZERO_CYCLES = (CLK_HZ / 1000000) * STEP_ZERO_US;
   localparam int STEP_HIGH_CYCLES = (CLK_HZ / 1000000) * STEP_HIGH_US;
   localparam logic [15:0] STEP_CURRENT_MA = 16'h03E8;

   localparam int NUM_REGS = 19;
   localparam logic [15:0] REG_BASE = 16'h001E;
   localparam logic [15:0] REG_AUTO_TUNING_ENABLE = 16'h001E;
   localparam logic [15:0] REG_IDENTIFIED_RESISTANCE = 16'h001F;
   localparam logic [15:0] REG_IDENTIFIED_INDUCTANCE = 16'h0020;
   localparam logic [15:0] REG_USER_RESISTANCE = 16'h0021;
   localparam logic [15:0] REG_USER_INDUCTANCE = 16'h0022;
   localparam logic [15:0] REG_TORQUE_CONSTANT = 16'h0023;
   localparam logic [15:0] REG_CURRENT_LOOP_PROP_GAIN = 16'h0024;
   localparam logic [15:0] REG_CURRENT_LOOP_INTEGRAL_GAIN = 16'h0025;
   localparam logic [15:0] REG_CURRENT_LOOP_COMP_COEFF = 16'h0026;
   localparam logic [15:0] REG_CURRENT_STEP_TEST = 16'h0027;
   localparam logic [15:0] REG_ENCODER_FEEDBACK_RESOLUTION = 16'h0028;
   localparam logic [15:0] REG_TRACKING_ERROR_THRESHOLD = 16'h0029;
   localparam logic [15:0] REG_SETTLE_ACCURACY_WINDOW = 16'h002A;
   localparam logic [15:0] REG_SETTLE_HOLD_DURATION = 16'h002B;
   localparam logic [15:0] REG_SETTLE_CHECK_DELAY = 16'h002C;
   localparam logic [15:0] REG_CLOSED_LOOP_MAX_CURRENT = 16'h002D;
   localparam logic [15:0] REG_CLOSED_LOOP_BASE_CURRENT_PCT = 16'h002E;
   localparam logic [15:0] REG_SPEED_FILTER_FIRST = 16'h002F;
   localparam logic [15:0] REG_SPEED_FILTER_SECOND = 16'h0030;

   // Index of each register within the bank
   localparam int IDX_AUTO = 0;
   localparam int IDX_IDENT_RES = 1;
   localparam int IDX_IDENT_IND = 2;
   localparam int IDX_USER_RES = 3;
   localparam int IDX_USER_IND = 4;
   localparam int IDX_TORQUE = 5;
   localparam int IDX_KP = 6;
   localparam int IDX_KI = 7;
   localparam int IDX_KC = 8;
   localparam int IDX_STEP = 9;
   localparam int IDX_ENC_RES = 10;
   localparam int IDX_TRACK = 11;
   localparam int IDX_WINDOW = 12;
   localparam int IDX_HOLD = 13;
   localparam int IDX_DELAY = 14;
   localparam int IDX_MAX_CUR = 15;
   localparam int IDX_BASE_PCT = 16;
   localparam int IDX_FILT1 = 17;
   localparam int IDX_FILT2 = 18;

   localparam logic [15:0] RESET_VAL [NUM_REGS] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h03E8, 16'h0001, 16'h00C8, 16'h03E8,
      16'h00C8, 16'h0100, 16'h0000, 16'h0FA0, 16'h07D0, 16'h000A, 16'h0032,
      16'h0064, 16'h0FA0, 16'h0032, 16'h00C8, 16'h0258};
   localparam logic [15:0] RANGE_MIN [NUM_REGS] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0001, 16'h0000, 16'h00C8,
      16'h0000, 16'h0000, 16'h0000, 16'h0100, 16'h0064, 16'h0001, 16'h0001,
      16'h0001, 16'h0000, 16'h0000, 16'h000A, 16'h000A};
   localparam logic [15:0] RANGE_MAX [NUM_REGS] = '{
      16'h0001, 16'hFFFF, 16'hFFFF, 16'h2710, 16'h000A, 16'h03E8, 16'h2710,
      16'h07D0, 16'h0400, 16'h0001, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'h1388, 16'h0064, 16'h1388, 16'h1388};
   localparam logic [NUM_REGS-1:0] WRITABLE = 19'h7FFF9;

   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
   localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

   localparam logic [1:0] MODE_OPEN_LOOP = 2'h0;
   localparam logic [1:0] MODE_SERVO_ONE = 2'h1;
   localparam logic [1:0] MODE_SERVO_TWO = 2'h2;

   typedef struct packed {
      logic [15:0] resistance_mohm;
      logic [15:0] inductance_mh;
      logic [15:0] torque_constant;
      logic [15:0] proportional_gain;
      logic [15:0] integral_gain;
      logic [15:0] comp_coeff;
      logic [15:0] max_current_ma;
      logic [15:0] base_current_pct;
      logic [15:0] speed_filter_first_hz;
      logic [15:0] speed_filter_second_hz;
      logic [15:0] encoder_lines;
   } slpb_loop_cfg_type;

   typedef struct packed {
      logic tracking_alarm;
      logic position_complete;
      logic step_test_active;
   } slpb_status_type;

endpackage : slpb_pkg

// *** slpb_param_bank.sv ***
// Purpose: Current loop and closed-loop supervision parameter bank of a stepper drive
// Assumes: Holding-register requests arrive already parsed from the serial frame
// Notes: Encoder pins are asynchronous and pass a three-stage synchroniser
// What this block does
// - One-bit automatic tuning enable, reset zero
// - Tuning off selects user winding resistance
// - Tuning off selects user winding inductance
// - Identified resistance and inductance are read-only
// - Torque constant applies only in servo two
// - Tuning selects generated or written loop gains
// - Compensation coefficient 0..1024, reset 256
// - Writing one runs zero-then-1000mA step test
// - Step register ignores zero, reads zero
// - Quadrature decode at four counts per line
// - Tracking error reaching threshold raises alarm in servo one or two
// - Complete after window held duration x 50us
// - Wait settle delay x 50us after pulses stop
// - Closed loop clamps current to configured maximum
// - Base current percentage 0..100, default 50
// - Two speed filter cutoffs 10..5000 Hz
// - Mode 0 open, 1 servo one, 2 servo two
`timescale 1ns/100ps
`default_nettype none
module slpb_param_bank #(
   parameter int STEP_ZERO_CYCLES = slpb_pkg::STEP_ZERO_CYCLES,
   parameter int STEP_HIGH_CYCLES = slpb_pkg::STEP_HIGH_CYCLES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Holding-register request
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [15:0] req_addr_in,
   input wire logic [15:0] req_wdata_in,
   // Holding-register answer
   output logic resp_valid_out,
   output logic [15:0] resp_rdata_out,
   output logic [7:0] resp_exception_out,
   // Operating mode and tuning engine
   input wire logic [1:0] motor_mode_in,
   input wire logic [15:0] ident_resistance_in,
   input wire logic [15:0] ident_inductance_in,
   input wire logic [15:0] auto_prop_gain_in,
   input wire logic [15:0] auto_integral_gain_in,
   // Position loop
   input wire logic enc_a_in,
   input wire logic enc_b_in,
   input wire logic cmd_pulse_in,
   input wire logic [31:0] cmd_position_in,
   input wire logic alarm_clear_in,
   input wire logic signed [15:0] current_request_in,
   // Results
   output logic [31:0] feedback_position_out,
   output logic signed [15:0] current_command_out,
   output slpb_pkg::slpb_loop_cfg_type loop_cfg_out,
   output slpb_pkg::slpb_status_type status_out
);

   typedef enum logic [1:0] {STEP_IDLE, STEP_ZERO, STEP_HIGH} slpb_step_state_type;

   logic [15:0] bank_q [slpb_pkg::NUM_REGS];
   logic [15:0] ident_res_q;
   logic [15:0] ident_ind_q;
   logic resp_valid_q;
   logic [15:0] resp_rdata_q;
   logic [7:0] resp_exc_q;
   logic [2:0] a_sync_q;
   logic [2:0] b_sync_q;
   logic a_q;
   logic b_q;
   logic a_prev_q;
   logic b_prev_q;
   logic [31:0] fb_pos_q;
   logic [11:0] tick_cnt_q;
   logic [15:0] delay_cnt_q;
   logic [15:0] hold_cnt_q;
   logic delay_done_q;
   logic complete_q;
   logic alarm_q;
   slpb_step_state_type step_state_q;
   logic [31:0] step_cnt_q;
   logic signed [15:0] cur_cmd_q;
   slpb_pkg::slpb_loop_cfg_type cfg_q;

   // Request decode
   wire logic [15:0] rel_addr = req_addr_in - slpb_pkg::REG_BASE;
   wire logic addr_hit = (req_addr_in >= slpb_pkg::REG_BASE) &&
      (rel_addr < 16'(slpb_pkg::NUM_REGS));
   wire logic [4:0] idx = rel_addr[4:0];
   wire logic idx_writable = addr_hit && slpb_pkg::WRITABLE[idx];
   wire logic value_ok = addr_hit && (req_wdata_in >= slpb_pkg::RANGE_MIN[idx]) &&
      (req_wdata_in <= slpb_pkg::RANGE_MAX[idx]);
   wire logic write_ok = req_valid_in && req_write_in && idx_writable && value_ok;
   wire logic step_start = write_ok && (idx == 5'(slpb_pkg::IDX_STEP)) &&
      (req_wdata_in == 16'h0001);
   wire logic [7:0] exc_d = !addr_hit ? slpb_pkg::EXC_ILLEGAL_ADDRESS :
      (req_write_in && !idx_writable) ? slpb_pkg::EXC_ILLEGAL_ADDRESS :
      (req_write_in && !value_ok) ? slpb_pkg::EXC_ILLEGAL_VALUE :
      slpb_pkg::EXC_NONE;
   wire logic [15:0] rdata_d = !addr_hit ? 16'h0000 :
      (idx == 5'(slpb_pkg::IDX_IDENT_RES)) ? ident_res_q :
      (idx == 5'(slpb_pkg::IDX_IDENT_IND)) ? ident_ind_q :
      (idx == 5'(slpb_pkg::IDX_STEP)) ? 16'h0000 :
      bank_q[idx];

   // Parameter storage, one flip-flop word per register
   genvar gi;
   generate
      for (gi = 0; gi < slpb_pkg::NUM_REGS; gi++)
      begin : g_bank
         always_ff @(posedge clk_in)
         begin
            if (rst_in)
               bank_q[gi] <= slpb_pkg::RESET_VAL[gi];
            else if (write_ok && (idx == 5'(gi)) && slpb_pkg::WRITABLE[gi])
               bank_q[gi] <= req_wdata_in;
         end
      end
   endgenerate

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         resp_valid_q <= 1'b0;
         resp_rdata_q <= 16'h0000;
         resp_exc_q <= slpb_pkg::EXC_NONE;
         ident_res_q <= 16'h0000;
         ident_ind_q <= 16'h0000;
      end
      else
      begin
         resp_valid_q <= req_valid_in;
         resp_rdata_q <= (req_valid_in && !req_write_in) ? rdata_d : 16'h0000;
         resp_exc_q <= req_valid_in ? exc_d : slpb_pkg::EXC_NONE;
         ident_res_q <= ident_resistance_in;
         ident_ind_q <= ident_inductance_in;
      end
   end

   // Effective loop configuration
   wire logic auto_on = bank_q[slpb_pkg::IDX_AUTO][0];
   wire logic servo_two = (motor_mode_in == slpb_pkg::MODE_SERVO_TWO);
   wire logic closed_loop = (motor_mode_in == slpb_pkg::MODE_SERVO_ONE) || servo_two;
   slpb_pkg::slpb_loop_cfg_type cfg_d;
   always_comb
   begin
      cfg_d.resistance_mohm = auto_on ? ident_res_q : bank_q[slpb_pkg::IDX_USER_RES];
      cfg_d.inductance_mh = auto_on ? ident_ind_q : bank_q[slpb_pkg::IDX_USER_IND];
      cfg_d.torque_constant = servo_two ? bank_q[slpb_pkg::IDX_TORQUE] : 16'h0000;
      cfg_d.proportional_gain = auto_on ? auto_prop_gain_in : bank_q[slpb_pkg::IDX_KP];
      cfg_d.integral_gain = auto_on ? auto_integral_gain_in : bank_q[slpb_pkg::IDX_KI];
      cfg_d.comp_coeff = bank_q[slpb_pkg::IDX_KC];
      cfg_d.max_current_ma = bank_q[slpb_pkg::IDX_MAX_CUR];
      cfg_d.base_current_pct = bank_q[slpb_pkg::IDX_BASE_PCT];
      cfg_d.speed_filter_first_hz = bank_q[slpb_pkg::IDX_FILT1];
      cfg_d.speed_filter_second_hz = bank_q[slpb_pkg::IDX_FILT2];
      cfg_d.encoder_lines = {2'b00, bank_q[slpb_pkg::IDX_ENC_RES][15:2]};
   end

   // Encoder pins: a change counts once stages two and three agree
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         a_sync_q <= 3'h0;
         b_sync_q <= 3'h0;
         a_q <= 1'b0;
         b_q <= 1'b0;
         a_prev_q <= 1'b0;
         b_prev_q <= 1'b0;
      end
      else
      begin
         a_sync_q <= {a_sync_q[1:0], enc_a_in};
         b_sync_q <= {b_sync_q[1:0], enc_b_in};
         if (a_sync_q[1] == a_sync_q[2])
            a_q <= a_sync_q[2];
         if (b_sync_q[1] == b_sync_q[2])
            b_q <= b_sync_q[2];
         a_prev_q <= a_q;
         b_prev_q <= b_q;
      end
   end

   // An edge of one phase alone is one count; edges of both phases in one cycle count none
   wire logic enc_step = (a_q ^ a_prev_q) ^ (b_q ^ b_prev_q);
   wire logic enc_up = a_q ^ b_prev_q;
   wire logic [31:0] track_err = cmd_position_in - fb_pos_q;
   wire logic [31:0] track_abs = track_err[31] ? (32'h0000_0000 - track_err) : track_err;
   wire logic err_alarm = track_abs >= {16'h0000, bank_q[slpb_pkg::IDX_TRACK]};
   wire logic in_window = track_abs <= {16'h0000, bank_q[slpb_pkg::IDX_WINDOW]};
   wire logic tick = (tick_cnt_q == 12'(slpb_pkg::TICK_CYCLES - 1));

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         fb_pos_q <= 32'h0000_0000;
      else if (enc_step)
         fb_pos_q <= enc_up ? fb_pos_q + 32'h0000_0001 : fb_pos_q - 32'h0000_0001;
   end

   // Alarm stays until cleared; a new breach in the clear cycle wins
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         alarm_q <= 1'b0;
      else if (closed_loop && err_alarm)
         alarm_q <= 1'b1;
      else if (alarm_clear_in)
         alarm_q <= 1'b0;
   end

   // Positioning completion timing on 50 us ticks
   always_ff @(posedge clk_in)
   begin
      if (rst_in || cmd_pulse_in)
         tick_cnt_q <= 12'h000;
      else
         tick_cnt_q <= tick ? 12'h000 : tick_cnt_q + 12'h001;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in || cmd_pulse_in)
      begin
         delay_cnt_q <= 16'h0000;
         delay_done_q <= 1'b0;
      end
      else if (!delay_done_q && tick)
      begin
         delay_cnt_q <= delay_cnt_q + 16'h0001;
         delay_done_q <= (delay_cnt_q + 16'h0001) >= bank_q[slpb_pkg::IDX_DELAY];
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in || cmd_pulse_in || !delay_done_q || !in_window)
      begin
         hold_cnt_q <= 16'h0000;
         complete_q <= 1'b0;
      end
      else if (!complete_q && tick)
      begin
         hold_cnt_q <= hold_cnt_q + 16'h0001;
         complete_q <= (hold_cnt_q + 16'h0001) >= bank_q[slpb_pkg::IDX_HOLD];
      end
   end

   // Current step test: zero phase, then fixed step current
   wire logic [31:0] step_last = (step_state_q == STEP_ZERO) ?
      32'(STEP_ZERO_CYCLES - 1) : 32'(STEP_HIGH_CYCLES - 1);
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         step_state_q <= STEP_IDLE;
         step_cnt_q <= 32'h0000_0000;
      end
      else
      begin
         case (step_state_q)
            STEP_IDLE:
            begin
               step_cnt_q <= 32'h0000_0000;
               if (step_start)
                  step_state_q <= STEP_ZERO;
            end
            STEP_ZERO, STEP_HIGH:
            begin
               if (step_cnt_q == step_last)
               begin
                  step_cnt_q <= 32'h0000_0000;
                  step_state_q <= (step_state_q == STEP_ZERO) ? STEP_HIGH : STEP_IDLE;
               end
               else
                  step_cnt_q <= step_cnt_q + 32'h0000_0001;
            end
            default:
               step_state_q <= STEP_IDLE;
         endcase
      end
   end

   // Winding current command, clamped in closed loop
   wire logic signed [16:0] cur_max = {1'b0, bank_q[slpb_pkg::IDX_MAX_CUR]};
   wire logic signed [16:0] cur_req = 17'(current_request_in);
   wire logic signed [15:0] cur_clamped = (cur_req > cur_max) ? cur_max[15:0] :
      (cur_req < -cur_max) ? 16'(-cur_max) : current_request_in;
   wire logic signed [15:0] cur_d = (step_state_q == STEP_ZERO) ? 16'h0000 :
      (step_state_q == STEP_HIGH) ? slpb_pkg::STEP_CURRENT_MA :
      closed_loop ? cur_clamped : current_request_in;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         cur_cmd_q <= 16'h0000;
         cfg_q <= '0;
      end
      else
      begin
         cur_cmd_q <= cur_d;
         cfg_q <= cfg_d;
      end
   end

   assign resp_valid_out = resp_valid_q;
   assign resp_rdata_out = resp_rdata_q;
   assign resp_exception_out = resp_exc_q;
   assign feedback_position_out = fb_pos_q;
   assign current_command_out = cur_cmd_q;
   assign loop_cfg_out = cfg_q;
   assign status_out.tracking_alarm = alarm_q;
   assign status_out.position_complete = complete_q;
   assign status_out.step_test_active = (step_state_q != STEP_IDLE);

endmodule : slpb_param_bank
`default_nettype wire

// *** slpb_param_bank_sva.sv ***
// Purpose: Port-level checks for the stepper loop parameter bank
// Assumes: Single clock domain, synchronous active-high reset
// Notes: Sees only top-level ports, attached by bind
`timescale 1ns/100ps
`default_nettype none
module slpb_param_bank_sva (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic req_valid_in,
   input wire logic req_write_in,
   input wire logic [15:0] req_addr_in,
   input wire logic [15:0] req_wdata_in,
   input wire logic resp_valid_out,
   input wire logic [15:0] resp_rdata_out,
   input wire logic [7:0] resp_exception_out,
   // Loop side
   input wire logic [1:0] motor_mode_in,
   input wire logic cmd_pulse_in,
   input wire logic alarm_clear_in,
   input wire logic signed [15:0] current_command_out,
   input wire slpb_pkg::slpb_loop_cfg_type loop_cfg_out,
   input wire slpb_pkg::slpb_status_type status_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence wr_s;
      req_valid_in && req_write_in;
   endsequence
   sequence step_begin_s;
      $rose(status_out.step_test_active) ##1 (current_command_out == 16'sh0000);
   endsequence
   resp_pulse_a: assert property (resp_valid_out == ($past(req_valid_in) & !$past(rst_in)))
      else $error("answer strobe misplaced");
   write_rdata_a: assert property (wr_s |=> resp_rdata_out == 16'h0000)
      else $error("write answered with data");
   ro_refuse_a: assert property (wr_s and (req_addr_in inside {16'h001F, 16'h0020})
      |=> resp_exception_out == 8'h02) else $error("read-only write not refused");
   unmapped_a: assert property (req_valid_in && !(req_addr_in inside {[16'h001E:16'h0030]})
      |=> resp_exception_out == 8'h02) else $error("unmapped access not refused");
   coeff_range_a: assert property (wr_s and (req_addr_in == 16'h0026
      && req_wdata_in > 16'h0400) |=> resp_exception_out == 8'h03)
      else $error("coefficient range taken");
   step_read_a: assert property (req_valid_in && !req_write_in && req_addr_in == 16'h0027
      |=> resp_rdata_out == 16'h0000 && resp_exception_out == 8'h00) else $error("step reg read");
   torque_mode_a: assert property (motor_mode_in != 2'h2
      |=> loop_cfg_out.torque_constant == 16'h0000) else $error("torque outside servo two");
   step_zero_a: assert property ($rose(status_out.step_test_active) |-> step_begin_s)
      else $error("step not from zero");
   alarm_hold_a: assert property (status_out.tracking_alarm && !alarm_clear_in
      |=> status_out.tracking_alarm) else $error("alarm dropped without clear");
   pulse_clear_a: assert property (cmd_pulse_in |=> !status_out.position_complete)
      else $error("complete while pulses arrive");
endmodule : slpb_param_bank_sva
bind slpb_param_bank slpb_param_bank_sva chk_inst (.clk_in, .rst_in, .req_valid_in,
   .req_write_in, .req_addr_in, .req_wdata_in, .resp_valid_out, .resp_rdata_out,
   .resp_exception_out, .motor_mode_in, .cmd_pulse_in, .alarm_clear_in,
   .current_command_out, .loop_cfg_out, .status_out);
`default_nettype wire

// *** slpb_master_model.sv ***
// Purpose: Holding-register master standing in front of the parameter bank
// Assumes: One-cycle request strobe, answer one edge later
// Notes: Released lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module slpb_master_model (
   // Clock
   input wire logic clk_in,
   // Request
   output logic req_valid_out,
   output logic req_write_out,
   output logic [15:0] req_addr_out,
   output logic [15:0] req_wdata_out,
   // Answer
   input wire logic resp_valid_in,
   input wire logic [15:0] resp_rdata_in,
   input wire logic [7:0] resp_exception_in
);
   initial
   begin
      req_valid_out = 1'b0;
      req_write_out = 1'b0;
      req_addr_out = 16'h0000;
      req_wdata_out = 16'h0000;
   end
   task automatic access(input logic w, input logic [15:0] a, d,
                         output logic ok, output logic [15:0] rd, output logic [7:0] ex);
      @(posedge clk_in);
      #1;
      req_valid_out = 1'b1;
      req_write_out = w;
      req_addr_out = a;
      req_wdata_out = d;
      @(posedge clk_in);
      #1;
      ok = resp_valid_in;
      rd = resp_rdata_in;
      ex = resp_exception_in;
      req_valid_out = 1'b0;
      req_write_out = ~w;
      req_addr_out = ~a;
      req_wdata_out = ~d;
   endtask : access
endmodule : slpb_master_model
`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the stepper loop parameter bank
// Assumes: Step phases shortened to 8 and 16 cycles
// Notes: One tick is 2000 clock cycles
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [15:0] ID_RES = 16'h0456;
   localparam logic [15:0] ID_IND = 16'h0007;
   localparam logic [15:0] AUTO_KP = 16'h0321;
   localparam logic [15:0] AUTO_KI = 16'h0123;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic req_valid_in, req_write_in, resp_valid_out;
   logic [15:0] req_addr_in, req_wdata_in, resp_rdata_out;
   logic [7:0] resp_exception_out;
   logic [1:0] motor_mode_in = 2'h0;
   logic enc_a_in = 1'b0, enc_b_in = 1'b0;
   logic cmd_pulse_in = 1'b0, alarm_clear_in = 1'b0;
   logic [31:0] cmd_position_in = 32'h00000000;
   logic [31:0] feedback_position_out;
   logic signed [15:0] current_request_in = 16'sh0000;
   logic signed [15:0] current_command_out;
   slpb_pkg::slpb_loop_cfg_type loop_cfg_out;
   slpb_pkg::slpb_status_type status_out;
   logic [1:0] quad [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0, ph = 0, n;
   slpb_master_model slpb_master_model_inst (.clk_in(clk_in), .req_valid_out(req_valid_in),
      .req_write_out(req_write_in), .req_addr_out(req_addr_in), .req_wdata_out(req_wdata_in),
      .resp_valid_in(resp_valid_out), .resp_rdata_in(resp_rdata_out),
      .resp_exception_in(resp_exception_out));
   slpb_param_bank #(.STEP_ZERO_CYCLES(8), .STEP_HIGH_CYCLES(16)) slpb_param_bank_inst (
      .clk_in, .rst_in, .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in,
      .resp_valid_out, .resp_rdata_out, .resp_exception_out, .motor_mode_in,
      .ident_resistance_in(ID_RES), .ident_inductance_in(ID_IND), .auto_prop_gain_in(AUTO_KP),
      .auto_integral_gain_in(AUTO_KI), .enc_a_in, .enc_b_in, .cmd_pulse_in, .cmd_position_in,
      .alarm_clear_in, .current_request_in, .feedback_position_out, .current_command_out,
      .loop_cfg_out, .status_out);
   initial forever #12.5 clk_in = ~clk_in;
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp)
      begin
         $display("unexpected %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask : cyc
   task automatic acc(input logic w, input logic [15:0] a, d, input logic [7:0] xe,
                      input logic [15:0] xr);
      logic ok;
      logic [15:0] rd;
      logic [7:0] ex;
      slpb_master_model_inst.access(w, a, d, ok, rd, ex);
      chk("strobe", 32'h1, {31'h0, ok});
      chk("exception", {24'h0, xe}, {24'h0, ex});
      chk("rdata", {16'h0, xr}, {16'h0, rd});
   endtask : acc
   task automatic enc(input int up, input int k);
      repeat (k)
      begin
         ph = (ph + (up ? 1 : 3)) % 4;
         {enc_a_in, enc_b_in} = quad[ph];
         cyc(4);
      end
      cyc(10);
   endtask : enc
   initial
   begin
      logic [15:0] a;
      cyc(20);
      rst_in = 1'b0;
      for (int i = 0; i < slpb_pkg::NUM_REGS; i++)
         acc(1'b0, slpb_pkg::REG_BASE + 16'(i), 16'h0000, 8'h00, (i == 1) ? ID_RES :
             (i == 2) ? ID_IND : slpb_pkg::RESET_VAL[i]);
      acc(1'b1, 16'h001F, 16'h0100, 8'h02, 16'h0000);
      acc(1'b1, 16'h0020, 16'h0002, 8'h02, 16'h0000);
      acc(1'b0, 16'h0020, 16'h0000, 8'h00, ID_IND);
      acc(1'b0, 16'h001D, 16'h0000, 8'h02, 16'h0000);
      acc(1'b1, 16'h0031, 16'h0001, 8'h02, 16'h0000);
      $display("test reset and map done");
      for (int i = 0; i < slpb_pkg::NUM_REGS; i++)
         if (slpb_pkg::WRITABLE[i] && i != slpb_pkg::IDX_STEP)
         begin
            a = slpb_pkg::REG_BASE + 16'(i);
            if (slpb_pkg::RANGE_MAX[i] != 16'hFFFF)
               acc(1'b1, a, slpb_pkg::RANGE_MAX[i] + 16'h0001, 8'h03, 16'h0000);
            if (slpb_pkg::RANGE_MIN[i] != 16'h0000)
               acc(1'b1, a, slpb_pkg::RANGE_MIN[i] - 16'h0001, 8'h03, 16'h0000);
            acc(1'b0, a, 16'h0000, 8'h00, slpb_pkg::RESET_VAL[i]);
            acc(1'b1, a, slpb_pkg::RANGE_MAX[i], 8'h00, 16'h0000);
            acc(1'b0, a, 16'h0000, 8'h00, slpb_pkg::RANGE_MAX[i]);
            acc(1'b1, a, slpb_pkg::RESET_VAL[i], 8'h00, 16'h0000);
         end
      $display("test ranges done");
      cyc(2);
      chk("user resistance", 32'h03E8, {16'h0, loop_cfg_out.resistance_mohm});
      chk("user inductance", 32'h0001, {16'h0, loop_cfg_out.inductance_mh});
      chk("written gain", 32'h03E8, {16'h0, loop_cfg_out.proportional_gain});
      chk("encoder lines", 32'h03E8, {16'h0, loop_cfg_out.encoder_lines});
      chk("coeff base", {16'h0100, 16'h0032},
          {loop_cfg_out.comp_coeff, loop_cfg_out.base_current_pct});
      chk("filters", {16'h00C8, 16'h0258},
          {loop_cfg_out.speed_filter_first_hz, loop_cfg_out.speed_filter_second_hz});
      acc(1'b1, 16'h001E, 16'h0001, 8'h00, 16'h0000);
      cyc(2);
      chk("ident resistance", {16'h0, ID_RES}, {16'h0, loop_cfg_out.resistance_mohm});
      chk("ident inductance", {16'h0, ID_IND}, {16'h0, loop_cfg_out.inductance_mh});
      chk("auto kp", {16'h0, AUTO_KP}, {16'h0, loop_cfg_out.proportional_gain});
      chk("auto ki", {16'h0, AUTO_KI}, {16'h0, loop_cfg_out.integral_gain});
      acc(1'b1, 16'h001E, 16'h0000, 8'h00, 16'h0000);
      motor_mode_in = 2'h2;
      cyc(3);
      chk("torque servo two", 32'h00C8, {16'h0, loop_cfg_out.torque_constant});
      motor_mode_in = 2'h1;
      cyc(3);
      chk("torque servo one", 32'h0000, {16'h0, loop_cfg_out.torque_constant});
      $display("test configuration done");
      enc(1, 8);
      chk("position up", 32'h8, feedback_position_out);
      enc(0, 4);
      chk("position down", 32'h4, feedback_position_out);
      cmd_position_in = 32'd2003;
      cyc(3);
      chk("alarm below", 32'h0, {31'h0, status_out.tracking_alarm});
      cmd_position_in = 32'd2004;
      cyc(3);
      chk("alarm reached", 32'h1, {31'h0, status_out.tracking_alarm});
      cmd_position_in = 32'h4;
      cyc(3);
      chk("alarm sticky", 32'h1, {31'h0, status_out.tracking_alarm});
      alarm_clear_in = 1'b1;
      cyc(1);
      alarm_clear_in = 1'b0;
      cyc(2);
      chk("alarm cleared", 32'h0, {31'h0, status_out.tracking_alarm});
      current_request_in = 16'sh7FFF;
      cyc(3);
      chk("clamp high", 32'h0FA0, {16'h0, current_command_out});
      current_request_in = 16'shEC78;
      cyc(3);
      chk("clamp low", 32'hF060, {16'h0, current_command_out});
      motor_mode_in = 2'h0;
      cyc(3);
      chk("open loop", 32'hEC78, {16'h0, current_command_out});
      $display("test loop supervision done");
      acc(1'b1, 16'h0027, 16'h0000, 8'h00, 16'h0000);
      cyc(2);
      chk("step idle", 32'h0, {31'h0, status_out.step_test_active});
      acc(1'b1, 16'h0027, 16'h0001, 8'h00, 16'h0000);
      chk("step active", 32'h1, {31'h0, status_out.step_test_active});
      cyc(1);
      chk("step zero", 32'h0, {16'h0, current_command_out});
      for (n = 0; n < 30 && current_command_out !== 16'sh03E8; n++)
         cyc(1);
      chk("step high", 32'h03E8, {16'h0, current_command_out});
      for (n = 0; n < 30 && status_out.step_test_active !== 1'b0; n++)
         cyc(1);
      chk("step end", 32'h0, {31'h0, status_out.step_test_active});
      $display("test step done");
      acc(1'b1, 16'h002C, 16'h0001, 8'h00, 16'h0000);
      acc(1'b1, 16'h002B, 16'h0001, 8'h00, 16'h0000);
      cmd_pulse_in = 1'b1;
      cyc(1);
      cmd_pulse_in = 1'b0;
      cyc(3985);
      chk("not yet complete", 32'h0, {31'h0, status_out.position_complete});
      for (n = 0; n < 40 && status_out.position_complete !== 1'b1; n++)
         cyc(1);
      chk("complete", 32'h1, {31'h0, status_out.position_complete});
      $display("test completion done");
      complete_run();
   end
endmodule : tb
`default_nettype wire
